/* File: design/sctc_top.sv */
// Sample and timing clock trim control with APB register access
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps

// What this block does
// - Slot config bit 0 enables slot A.
// - Bypass bit takes sample clock from pin one.
// - Sample clock enable bit gates sample clock.
// - Six-bit sample trim, 0.6 kHz per step.
// - Larger sample trim code gives lower frequency.
// - Eight-bit timing trim, 109 kHz per step.
// - Timing trim all zeros gives lowest frequency.
// - All ones highest; 0x98 gives default frequency.
module sctc_top
    import sctc_pkg::*;
(
    input wire logic pclk, // System clock, 250 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write when high
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic general_pin_one_in, // External sample clock input
    output logic sample_tick, // Sample clock tick
    output logic first_slot_tick, // Slot A sample trigger
    output logic timing_tick, // Timing clock tick
    output logic first_slot_enable, // Slot A enable level
    output logic [1:0] sample_sync_source_select, // Sync source selection
    output logic [15:0] external_sync_startup_word, // Sync startup word
    output logic general_pin_one_oe // Pin one output enable
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Map a byte address to a register index; unaligned maps nowhere
    function automatic logic [7:0] reg_index(input logic [11:0] addr);
        reg_index = (addr[1:0] == 2'b00) ? addr[9:2] : 8'hff;
        if (addr[11:10] != 2'b00)
        begin
            reg_index = 8'hff;
        end
    endfunction

    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx == SCTC_IDX_SLOT_CFG) || (idx == SCTC_IDX_SYNC_STARTUP) ||
                    (idx == SCTC_IDX_SAMPLE_CTRL) || (idx == SCTC_IDX_TIMING_TRIM) ||
                    (idx == SCTC_IDX_PIN_CFG) || (idx == SCTC_IDX_STATUS);
    endfunction

    // Larger sample code means a slower clock
    function automatic logic [15:0] sample_step_of(input logic [5:0] code);
        int f;
        f = SCTC_SMP_BASE + (SCTC_SMP_CENTER - int'(code)) * SCTC_SMP_PER_LSB;
        sample_step_of = 16'(f);
    endfunction

    // Larger timing code means a faster clock
    function automatic logic [15:0] timing_step_of(input logic [7:0] code);
        int f;
        f = SCTC_TIM_BASE + (int'(code) - SCTC_TIM_DEFAULT) * SCTC_TIM_PER_LSB;
        timing_step_of = 16'(f);
    endfunction

    // Merge written bytes of the low half word
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
        merge16 = old;
        if (strb[0])
        begin
            merge16[7:0] = wd[7:0];
        end
        if (strb[1])
        begin
            merge16[15:8] = wd[15:8];
        end
    endfunction

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [15:0] slot_cfg_q;
    logic [15:0] slot_cfg_d;
    logic [15:0] sync_startup_q;
    logic [15:0] sync_startup_d;
    logic [15:0] sample_ctrl_q;
    logic [15:0] sample_ctrl_d;
    logic [15:0] timing_trim_q;
    logic [15:0] timing_trim_d;
    logic [15:0] pin_cfg_q;
    logic [15:0] pin_cfg_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic [15:0] tick_count_q;
    logic [15:0] tick_count_d;

    logic [7:0] idx;
    logic wr_go;
    logic rd_setup;
    logic [31:0] status_word;

    assign idx = reg_index(paddr);
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~is_mapped(idx);
    assign wr_go = psel & penable & pwrite & is_mapped(idx);
    assign rd_setup = psel & ~penable & ~pwrite;

    // Field views
    logic slot_a_en;
    logic bypass;
    logic sample_en;
    logic [5:0] sample_trim;
    logic [7:0] timing_trim;
    assign slot_a_en = slot_cfg_q[SCTC_BIT_SLOT_A_EN];
    assign bypass = sample_ctrl_q[SCTC_BIT_BYPASS];
    assign sample_en = sample_ctrl_q[SCTC_BIT_SAMPLE_EN];
    assign sample_trim = sample_ctrl_q[SCTC_SAMPLE_TRIM_LSB +: SCTC_SAMPLE_TRIM_W];
    assign timing_trim = timing_trim_q[SCTC_TIMING_TRIM_LSB +: SCTC_TIMING_TRIM_W];

    assign status_word = {tick_count_q, 13'h0000, bypass, slot_a_en & sample_en, sample_en};

    // Next values of the register file; read data is captured in setup
    always_comb
    begin
        slot_cfg_d = slot_cfg_q;
        sync_startup_d = sync_startup_q;
        sample_ctrl_d = sample_ctrl_q;
        timing_trim_d = timing_trim_q;
        pin_cfg_d = pin_cfg_q;
        prdata_d = prdata_q;
        if (wr_go)
        begin
            unique case (idx)
                SCTC_IDX_SLOT_CFG: slot_cfg_d = merge16(slot_cfg_q, pwdata, pstrb);
                SCTC_IDX_SYNC_STARTUP: sync_startup_d = merge16(sync_startup_q, pwdata, pstrb);
                SCTC_IDX_SAMPLE_CTRL: sample_ctrl_d = merge16(sample_ctrl_q, pwdata, pstrb);
                SCTC_IDX_TIMING_TRIM: timing_trim_d = merge16(timing_trim_q, pwdata, pstrb);
                SCTC_IDX_PIN_CFG: pin_cfg_d = merge16(pin_cfg_q, pwdata, pstrb);
                default: ; // Status is read only
            endcase
        end
        if (rd_setup)
        begin
            unique case (idx)
                SCTC_IDX_SLOT_CFG: prdata_d = {16'h0000, slot_cfg_q};
                SCTC_IDX_SYNC_STARTUP: prdata_d = {16'h0000, sync_startup_q};
                SCTC_IDX_SAMPLE_CTRL: prdata_d = {16'h0000, sample_ctrl_q};
                SCTC_IDX_TIMING_TRIM: prdata_d = {16'h0000, timing_trim_q};
                SCTC_IDX_PIN_CFG: prdata_d = {16'h0000, pin_cfg_q};
                SCTC_IDX_STATUS: prdata_d = status_word;
                default: prdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slot_cfg_q <= SCTC_RST_SLOT_CFG;
            sync_startup_q <= SCTC_RST_SYNC_STARTUP;
            sample_ctrl_q <= SCTC_RST_SAMPLE_CTRL;
            timing_trim_q <= SCTC_RST_TIMING_TRIM;
            pin_cfg_q <= SCTC_RST_PIN_CFG;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            slot_cfg_q <= slot_cfg_d;
            sync_startup_q <= sync_startup_d;
            sample_ctrl_q <= sample_ctrl_d;
            timing_trim_q <= timing_trim_d;
            pin_cfg_q <= pin_cfg_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;

    // The startup word is only carried; choosing it is software's job
    assign external_sync_startup_word = sync_startup_q;
    assign sample_sync_source_select = pin_cfg_q[SCTC_SYNC_SEL_LSB +: 2];
    assign general_pin_one_oe = pin_cfg_q[SCTC_BIT_PIN1_OE];
    assign first_slot_enable = slot_a_en;

    // ------------------------------------------------------------
    // Oscillators
    // ------------------------------------------------------------
    logic [15:0] sample_step;
    logic [15:0] timing_step;
    logic nco_sample_tick;

    assign sample_step = sample_step_of(sample_trim);
    assign timing_step = timing_step_of(timing_trim);

    // Internal oscillator idles in bypass to save power
    sctc_nco #(.MODULUS(SCTC_SMP_MODULUS)) u_sample_osc
    (
        .pclk(pclk),
        .presetn(presetn),
        .run(sample_en & ~bypass),
        .step(sample_step),
        .tick(nco_sample_tick)
    );

    sctc_nco #(.MODULUS(SCTC_TIM_MODULUS)) u_timing_osc
    (
        .pclk(pclk),
        .presetn(presetn),
        .run(1'b1),
        .step(timing_step),
        .tick(timing_tick)
    );

    // ------------------------------------------------------------
    // Sample clock selection and gating
    // ------------------------------------------------------------
    logic pin_q;
    logic pin_d;
    logic pin_rise;
    logic sample_src;
    logic sample_tick_q;
    logic sample_tick_d;
    logic slot_tick_q;
    logic slot_tick_d;

    // Pin is synchronous, so one stage suffices for edge finding
    assign pin_rise = general_pin_one_in & ~pin_q;
    // External rising edges replace the internal oscillator
    assign sample_src = bypass ? pin_rise : nco_sample_tick;

    always_comb
    begin
        pin_d = general_pin_one_in;
        sample_tick_d = sample_src & sample_en;
        slot_tick_d = sample_src & sample_en & slot_a_en;
        tick_count_d = tick_count_q;
        if (sample_tick_q)
        begin
            tick_count_d = 16'(tick_count_q + 16'h0001);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_q <= 1'b0;
            sample_tick_q <= 1'b0;
            slot_tick_q <= 1'b0;
            tick_count_q <= 16'h0000;
        end
        else
        begin
            pin_q <= pin_d;
            sample_tick_q <= sample_tick_d;
            slot_tick_q <= slot_tick_d;
            tick_count_q <= tick_count_d;
        end
    end

    assign sample_tick = sample_tick_q;
    assign first_slot_tick = slot_tick_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_slot_a_gate: assert property (@(posedge pclk) disable iff (!presetn)
        first_slot_tick |-> $past(slot_a_en) && sample_tick)
        else $error("Slot A ticked while disabled");

    a_slot_a_follow: assert property (@(posedge pclk) disable iff (!presetn)
        (sample_tick && $past(slot_a_en)) |-> first_slot_tick)
        else $error("Slot A missed a sample tick");

    a_bypass_edge: assert property (@(posedge pclk) disable iff (!presetn)
        (bypass && sample_en && general_pin_one_in && !pin_q) |=> sample_tick)
        else $error("External clock edge not passed on");

    a_bypass_only_pin: assert property (@(posedge pclk) disable iff (!presetn)
        (bypass && !(general_pin_one_in && !pin_q)) |=> !sample_tick)
        else $error("Sample tick without external edge in bypass");

    a_sample_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !sample_en [*2] |-> !sample_tick ##1 !sample_tick)
        else $error("Sample clock ran while disabled");

    a_sample_trim_map: assert property (@(posedge pclk) disable iff (!presetn)
        (sample_trim == 6'h12) |-> (sample_step == 16'h01a0))
        else $error("Sample trim reset code gives wrong rate");

    a_sample_trim_dir: assert property (@(posedge pclk) disable iff (!presetn)
        ((sample_trim == 6'h00) |-> (sample_step == 16'h020c)) and
        ((sample_trim == 6'h22) |-> (sample_step == 16'h0140)) and
        ((sample_trim == 6'h3f) |-> (sample_step == 16'h0092)))
        else $error("Sample trim direction wrong");

    a_timing_trim_lsb: assert property (@(posedge pclk) disable iff (!presetn)
        // A wrap from all ones to zero is not a one-step increase
        ($changed(timing_trim) && (timing_trim != 8'h00) &&
        (timing_trim == $past(timing_trim) + 8'h01)) |->
        (timing_step == 16'($past(timing_step) + 16'h006d)))
        else $error("Timing trim step size wrong");

    a_timing_trim_low: assert property (@(posedge pclk) disable iff (!presetn)
        (timing_trim == 8'h00) |-> (timing_step == 16'h3c48))
        else $error("Timing trim zero not lowest");

    a_timing_trim_high: assert property (@(posedge pclk) disable iff (!presetn)
        ((timing_trim == 8'hff) |-> (timing_step == 16'ha8db)) and
        ((timing_trim == 8'h98) |-> (timing_step == 16'h7d00)))
        else $error("Timing trim top or default wrong");

endmodule

/* File: design/sctc_pkg.sv */
// Constants for the sample and timing clock trim control block
package sctc_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] SCTC_IDX_SLOT_CFG = 8'h11;
    localparam logic [7:0] SCTC_IDX_SYNC_STARTUP = 8'h38;
    localparam logic [7:0] SCTC_IDX_SAMPLE_CTRL = 8'h4b;
    localparam logic [7:0] SCTC_IDX_TIMING_TRIM = 8'h4d;
    localparam logic [7:0] SCTC_IDX_PIN_CFG = 8'h4f;
    localparam logic [7:0] SCTC_IDX_STATUS = 8'h50;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] SCTC_RST_SLOT_CFG = 16'h1000;
    localparam logic [15:0] SCTC_RST_SYNC_STARTUP = 16'h0000;
    localparam logic [15:0] SCTC_RST_SAMPLE_CTRL = 16'h2612;
    localparam logic [15:0] SCTC_RST_TIMING_TRIM = 16'h0098;
    localparam logic [15:0] SCTC_RST_PIN_CFG = 16'h0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SCTC_BIT_SLOT_A_EN = 0;
    localparam int SCTC_BIT_BYPASS = 8;
    localparam int SCTC_BIT_SAMPLE_EN = 7;
    localparam int SCTC_SAMPLE_TRIM_LSB = 0;
    localparam int SCTC_SAMPLE_TRIM_W = 6;
    localparam int SCTC_TIMING_TRIM_LSB = 0;
    localparam int SCTC_TIMING_TRIM_W = 8;
    localparam int SCTC_SYNC_SEL_LSB = 2;
    localparam int SCTC_BIT_PIN1_IE = 5;
    localparam int SCTC_BIT_PIN1_OE = 6;

    // ------------------------------------------------------------
    // Oscillator models: frequency in fixed units, phase modulus
    // ------------------------------------------------------------
    // Sample clock in units of 100 Hz, 250 MHz / 100 Hz per wrap
    localparam int SCTC_SMP_BASE = 320;
    localparam int SCTC_SMP_CENTER = 34;
    localparam int SCTC_SMP_PER_LSB = 6;
    localparam logic [21:0] SCTC_SMP_MODULUS = 22'd2500000;
    // Timing clock in units of 1 kHz, 250 MHz / 1 kHz per wrap
    localparam int SCTC_TIM_BASE = 32000;
    localparam int SCTC_TIM_DEFAULT = 152;
    localparam int SCTC_TIM_PER_LSB = 109;
    localparam logic [21:0] SCTC_TIM_MODULUS = 22'd250000;

endpackage

/* File: design/sctc_nco.sv */
// Phase accumulator that emits one-cycle ticks at a programmable rate
`timescale 1ns/100ps
module sctc_nco
#(
    parameter logic [21:0] MODULUS = 22'h3fffff
)
(
    input wire logic pclk, // System clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic run, // Accumulate while high
    input wire logic [15:0] step, // Phase added per clock
    output logic tick // One-cycle pulse on phase wrap
);

    // ------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------
    logic [21:0] acc_q;
    logic [21:0] acc_d;
    logic tick_q;
    logic tick_d;
    logic [22:0] sum;

    // Wrap by subtraction keeps the average rate exact, no drift
    always_comb
    begin
        sum = {1'b0, acc_q} + {7'h00, step};
        acc_d = acc_q;
        tick_d = 1'b0;
        if (run)
        begin
            if (sum >= {1'b0, MODULUS})
            begin
                acc_d = 22'(sum - {1'b0, MODULUS});
                tick_d = 1'b1;
            end
            else
            begin
                acc_d = sum[21:0];
            end
        end
    end

    // Register stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_q <= 22'h000000;
            tick_q <= 1'b0;
        end
        else
        begin
            acc_q <= acc_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule

/* File: test/sctc_host_model.sv */
// Host-side APB master that programs the clock trim registers
`timescale 1ns/100ps
module sctc_host_model
    import sctc_pkg::*;
(
    input wire logic pclk, // System clock
    output logic psel, // APB select
    output logic penable, // APB access phase
    output logic pwrite, // APB direction
    output logic [11:0] paddr, // APB byte address
    output logic [31:0] pwdata, // APB write data
    output logic [3:0] pstrb, // APB byte strobes
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr // APB error
);
    // ------------------------------------------------------------
    // Bus idle from time zero
    // ------------------------------------------------------------
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
    end

    // One transfer; request held until pready is seen at an edge
    task automatic xfer(input logic wr_en, input logic [11:0] addr, input logic [31:0] wd,
        output logic [31:0] rd_data, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd_data = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Word access by register index
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        xfer(1'b1, {2'b00, idx, 2'b00}, wd, d, e);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d);
        logic e;
        xfer(1'b0, {2'b00, idx, 2'b00}, 32'h0, d, e);
    endtask

    // Startup word follows the sync source: only pin-driven sync needs it
    task automatic set_sync(input logic [1:0] sel);
        wr(SCTC_IDX_PIN_CFG, {28'h0, sel, 2'b00});
        wr(SCTC_IDX_SYNC_STARTUP, (sel == 2'b01 || sel == 2'b10) ? 32'h4000 : 32'h0);
    endtask

    // Pin one must be an input before the oscillator is bypassed
    task automatic prep_bypass;
        wr(SCTC_IDX_PIN_CFG, 32'h0000_0020);
    endtask
endmodule

/* File: test/sctc_tb_top.sv */
// Self-checking bench for the sample and timing clock trim control block
`timescale 1ns/100ps
module sctc_tb_top
    import sctc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic pin = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic sample_tick, first_slot_tick, timing_tick, first_slot_enable, pin_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [1:0] sync_sel;
    logic [15:0] startup_word;
    int bad_count = 0;
    int total_checks = 0;
    int n_smp = 0;
    int n_slot = 0;
    int n_tim = 0;

    // ------------------------------------------------------------
    // Clock, instances and tick counters
    // ------------------------------------------------------------
    always #2 pclk = ~pclk;

    sctc_top sctc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .general_pin_one_in(pin),
        .sample_tick(sample_tick), .first_slot_tick(first_slot_tick),
        .timing_tick(timing_tick), .first_slot_enable(first_slot_enable),
        .sample_sync_source_select(sync_sel), .external_sync_startup_word(startup_word),
        .general_pin_one_oe(pin_oe));

    sctc_host_model sctc_host_model_inst (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // Counters are read on the falling edge so they never race the increment
    always @(posedge pclk)
    begin
        if (sample_tick === 1'b1) n_smp++;
        if (first_slot_tick === 1'b1) n_slot++;
        if (timing_tick === 1'b1) n_tim++;
    end

    // ------------------------------------------------------------
    // Compare, expectation and closing helpers
    // ------------------------------------------------------------
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Tick counts depend on the oscillator's start phase, so one extra is allowed
    task automatic cmp_rng(input string what, input longint lo, input int seen);
        total_checks++;
        if (seen < lo || seen > lo + 1)
        begin
            bad_count++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, lo + 1, seen);
        end
    endtask

    function automatic longint smp_exp(input int w, input int trim);
        return longint'(w) * (SCTC_SMP_BASE + (SCTC_SMP_CENTER - trim) * SCTC_SMP_PER_LSB)
            / int'(SCTC_SMP_MODULUS);
    endfunction

    function automatic longint tim_exp(input int w, input int trim);
        return longint'(w) * (SCTC_TIM_BASE + (trim - SCTC_TIM_DEFAULT) * SCTC_TIM_PER_LSB)
            / int'(SCTC_TIM_MODULUS);
    endfunction

    task automatic window(input int w, output int ds, output int dsl, output int dt);
        int s0, l0, t0;
        @(negedge pclk);
        s0 = n_smp;
        l0 = n_slot;
        t0 = n_tim;
        repeat (w) @(negedge pclk);
        ds = n_smp - s0;
        dsl = n_slot - l0;
        dt = n_tim - t0;
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog sized well above the roughly 60000 cycles of the tests
    initial
    begin
        repeat (90000) @(posedge pclk);
        bad_count++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] d;
        logic [31:0] d2;
        logic e;
        logic [7:0] tt;
        int ds, dsl, dt;
        logic [7:0] tims [5];
        void'($urandom(4402));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values
        sctc_host_model_inst.rd(SCTC_IDX_SLOT_CFG, d);
        cmp("slot_cfg", 32'h1000, d);
        sctc_host_model_inst.rd(SCTC_IDX_SYNC_STARTUP, d);
        cmp("startup", 32'h0000, d);
        sctc_host_model_inst.rd(SCTC_IDX_SAMPLE_CTRL, d);
        cmp("sample_ctrl", 32'h2612, d);
        sctc_host_model_inst.rd(SCTC_IDX_TIMING_TRIM, d);
        cmp("timing_trim", 32'h0098, d);
        cmp("slot_en_out", 32'h0, {31'h0, first_slot_enable});
        $display("test reset values done");
        // Every sync source with its startup word
        for (int s = 0; s < 4; s++)
        begin
            sctc_host_model_inst.set_sync(s[1:0]);
            // The last write lands at the edge the task returns on
            @(negedge pclk);
            cmp("sync_sel", 32'(s), {30'h0, sync_sel});
            cmp("startup_out", (s == 1 || s == 2) ? 32'h4000 : 32'h0, {16'h0, startup_word});
        end
        sctc_host_model_inst.wr(SCTC_IDX_PIN_CFG, 32'h0000_0040);
        @(negedge pclk);
        cmp("pin_oe_set", 32'h1, {31'h0, pin_oe});
        $display("test sync startup done");
        // Unmapped and unaligned addresses
        sctc_host_model_inst.xfer(1'b0, 12'h080, 32'h0, d, e);
        cmp("unmapped_err", 32'h1, {31'h0, e});
        sctc_host_model_inst.xfer(1'b0, 12'h12d, 32'h0, d, e);
        cmp("unaligned_err", 32'h1, {31'h0, e});
        $display("test bad address done");
        // Timing trim: boundary codes, default and a random one
        // The step from 0x98 to 0x99 exercises the per-code increment
        tims = '{8'h00, 8'h98, 8'h99, 8'hff, 8'($urandom)};
        foreach (tims[i])
        begin
            tt = tims[i];
            sctc_host_model_inst.wr(SCTC_IDX_TIMING_TRIM, {24'h0, tt});
            sctc_host_model_inst.rd(SCTC_IDX_TIMING_TRIM, d);
            cmp("timing_rb", {24'h0, tt}, d);
            window(2000, ds, dsl, dt);
            cmp_rng("timing_ticks", tim_exp(2000, int'(tt)), dt);
        end
        $display("test timing trim done");
        // Sample clock gated off, then fastest and slowest trim
        sctc_host_model_inst.wr(SCTC_IDX_SAMPLE_CTRL, 32'h2600);
        window(10000, ds, dsl, dt);
        cmp("gated_ticks", 32'h0, 32'(ds));
        sctc_host_model_inst.wr(SCTC_IDX_SAMPLE_CTRL, 32'h2680);
        window(20000, ds, dsl, dt);
        cmp_rng("fast_ticks", smp_exp(20000, 0), ds);
        cmp("slot_off_ticks", 32'h0, 32'(dsl));
        sctc_host_model_inst.wr(SCTC_IDX_SAMPLE_CTRL, 32'h26bf);
        window(20000, ds, dsl, dt);
        cmp_rng("slow_ticks", smp_exp(20000, 63), ds);
        $display("test sample trim done");
        // External clock on pin one drives one tick per rising edge
        sctc_host_model_inst.prep_bypass();
        sctc_host_model_inst.wr(SCTC_IDX_SLOT_CFG, 32'h1001);
        @(negedge pclk);
        cmp("slot_en_out", 32'h1, {31'h0, first_slot_enable});
        sctc_host_model_inst.wr(SCTC_IDX_SAMPLE_CTRL, 32'h2780);
        sctc_host_model_inst.rd(SCTC_IDX_STATUS, d);
        cmp("status", 32'h7, {29'h0, d[2:0]});
        cmp("pin_oe", 32'h0, {31'h0, pin_oe});
        @(negedge pclk);
        ds = n_smp;
        dsl = n_slot;
        repeat (10)
        begin
            @(posedge pclk);
            pin <= 1'b1;
            repeat (4) @(posedge pclk);
            pin <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        repeat (4) @(negedge pclk);
        cmp("bypass_ticks", 32'd10, 32'(n_smp - ds));
        cmp("slot_ticks", 32'd10, 32'(n_slot - dsl));
        sctc_host_model_inst.rd(SCTC_IDX_STATUS, d2);
        cmp("tick_count", 32'd10, 32'(16'(d2[31:16] - d[31:16])));
        $display("test bypass done");
        end_sim();
    end
endmodule
